// ---- src/vicp_host.sv ----
`timescale 1ns/1ps
// Host controller: AHB-Lite registers driving the interrupt controller pins
module vicp_host (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic cs_n,
	output logic wr_n,
	output logic rd_n,
	output logic ack_strobe_n,
	output logic port_select_bit,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	input wire logic [2:0] chain_id_bus,
	input wire logic role_select_or_buffer_gate_in,
	output logic role_select_or_buffer_gate_out,
	output logic role_select_or_buffer_gate_oe,
	input wire logic int_in
);
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_BUS = 2'b01,
		M_ACK = 2'b10
	} vicp_mst_e;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	vicp_mst_e mst_q;
	logic hreadyout_q, hresp_q;
	logic [31:0] hrdata_q;
	logic dph_valid_q, dph_write_q, dev_pend_q;
	logic [7:0] dph_addr_q;
	logic ack_go_q, auto_ack_q, buffered_q, master_q;
	logic [1:0] ack_cnt_q, ack_left_q, ack_idx_q;
	logic [23:0] vector_q;
	logic [7:0] last_rd_q;
	logic [2:0] chain_q;
	logic int_q, gate_q, role_out_q, role_oe_q;
	logic a_acc, reg_wr, bus_launch, ack_launch, ack_next, seq_start;
	logic seq_busy, seq_done, seq_ps;
	logic [7:0] seq_rdata;
	logic [1:0] ack_total;
	logic [31:0] rd_mux;
	vicp_pkg::vicp_kind_e seq_kind;

	// True for the two words that reach through to the device
	function automatic logic vicp_is_dev(input logic [7:0] a);
		return (a == vicp_pkg::OFS_DEV_PORT0) || (a == vicp_pkg::OFS_DEV_PORT1);
	endfunction : vicp_is_dev

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;
	assign role_select_or_buffer_gate_out = role_out_q;
	assign role_select_or_buffer_gate_oe = role_oe_q;

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	assign a_acc = hsel && htrans[1] && hready;
	assign reg_wr = dph_valid_q && dph_write_q && hreadyout_q && !vicp_is_dev(dph_addr_q);

	// Address phase capture, held over stalled data phases
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dph_valid_q <= 1'b0;
			dph_write_q <= 1'b0;
			dph_addr_q <= 8'h00;
		end else if (hready) begin
			dph_valid_q <= a_acc;
			dph_write_q <= hwrite;
			dph_addr_q <= haddr[7:0];
		end
	end

	// Device-window access pending until the strobe engine takes it
	always_ff @(posedge clk_sys) begin
		if (!rst_n) dev_pend_q <= 1'b0;
		else if (a_acc && vicp_is_dev(haddr[7:0])) dev_pend_q <= 1'b1;
		else if (bus_launch) dev_pend_q <= 1'b0;
	end

	// Ready stalls for device-window accesses only
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			hresp_q <= 1'b0;
			if (a_acc && vicp_is_dev(haddr[7:0])) hreadyout_q <= 1'b0;
			else if (mst_q == M_BUS && seq_done) hreadyout_q <= 1'b1;
		end
	end

	// Read mux for the own registers
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (haddr[7:0] == vicp_pkg::OFS_CTRL) begin
			rd_mux[vicp_pkg::CTRL_ACK_GO] = ack_go_q;
			rd_mux[vicp_pkg::CTRL_AUTO_ACK] = auto_ack_q;
			rd_mux[vicp_pkg::CTRL_BUFFERED] = buffered_q;
			rd_mux[vicp_pkg::CTRL_MASTER] = master_q;
			rd_mux[vicp_pkg::CTRL_ACK_CNT_LSB +: 2] = ack_cnt_q;
		end else if (haddr[7:0] == vicp_pkg::OFS_STATUS) begin
			rd_mux[vicp_pkg::ST_BUSY] = (mst_q != M_IDLE) || seq_busy || ack_go_q;
			rd_mux[vicp_pkg::ST_INT] = int_q;
			rd_mux[vicp_pkg::ST_GATE] = gate_q;
			rd_mux[vicp_pkg::ST_CHAIN_LSB +: 3] = chain_q;
		end else if (haddr[7:0] == vicp_pkg::OFS_VECTOR) begin
			rd_mux[23:0] = vector_q;
		end else if (haddr[7:0] == vicp_pkg::OFS_LAST_RD) begin
			rd_mux[7:0] = last_rd_q;
		end
	end

	// Read data: own registers at once, device bytes when the cycle ends
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hrdata_q <= 32'h0000_0000;
			last_rd_q <= 8'h00;
		end else if (a_acc && !hwrite) begin
			hrdata_q <= rd_mux;
		end else if (mst_q == M_BUS && seq_done && !dph_write_q) begin
			hrdata_q <= {24'h00_0000, seq_rdata};
			last_rd_q <= seq_rdata;
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			auto_ack_q <= 1'b0;
			buffered_q <= 1'b0;
			master_q <= vicp_pkg::CTRL_MASTER_RST;
			ack_cnt_q <= vicp_pkg::CTRL_ACK_CNT_RST;
		end else if (reg_wr && dph_addr_q == vicp_pkg::OFS_CTRL) begin
			auto_ack_q <= hwdata[vicp_pkg::CTRL_AUTO_ACK];
			buffered_q <= hwdata[vicp_pkg::CTRL_BUFFERED];
			master_q <= hwdata[vicp_pkg::CTRL_MASTER];
			ack_cnt_q <= hwdata[vicp_pkg::CTRL_ACK_CNT_LSB +: 2];
		end
	end

	// Acknowledge request: a new write wins over the clear
	always_ff @(posedge clk_sys) begin
		if (!rst_n) ack_go_q <= 1'b0;
		else if (reg_wr && dph_addr_q == vicp_pkg::OFS_CTRL && hwdata[vicp_pkg::CTRL_ACK_GO]) ack_go_q <= 1'b1;
		else if (ack_launch) ack_go_q <= 1'b0;
	end

	// Role pin: strap when unbuffered, released to the device when buffered
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			role_out_q <= 1'b0;
			role_oe_q <= 1'b0;
		end else begin
			role_out_q <= master_q;
			role_oe_q <= !buffered_q;
		end
	end

	// Pin levels seen by software
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			int_q <= 1'b0;
			gate_q <= 1'b0;
			chain_q <= 3'h0;
		end else begin
			int_q <= int_in;
			gate_q <= role_select_or_buffer_gate_in;
			if (!ack_strobe_n) chain_q <= chain_id_bus;
		end
	end

	// ----------------------------------------
	// Sequencing of device cycles
	// ----------------------------------------
	assign ack_total = (ack_cnt_q == 2'h0) ? 2'h1 : ack_cnt_q;
	assign bus_launch = (mst_q == M_IDLE) && dev_pend_q && !seq_busy;
	assign ack_launch = (mst_q == M_IDLE) && !dev_pend_q && !seq_busy && (ack_go_q || (auto_ack_q && int_q));
	assign ack_next = (mst_q == M_ACK) && seq_done && (ack_left_q != 2'h1);
	assign seq_start = bus_launch || ack_launch || ack_next;
	assign seq_ps = dph_addr_q[vicp_pkg::DEV_PS_BIT];

	// Kind of the cycle handed to the strobe engine
	always_comb begin
		seq_kind = vicp_pkg::VICP_K_ACK;
		if (bus_launch) seq_kind = dph_write_q ? vicp_pkg::VICP_K_WRITE : vicp_pkg::VICP_K_READ;
	end

	// Master state machine
	always_ff @(posedge clk_sys) begin
		if (!rst_n) mst_q <= M_IDLE;
		else begin
			case (mst_q)
				M_IDLE: if (bus_launch) mst_q <= M_BUS;
				else if (ack_launch) mst_q <= M_ACK;
				M_BUS: if (seq_done) mst_q <= M_IDLE;
				M_ACK: if (seq_done && ack_left_q == 2'h1) mst_q <= M_IDLE;
				default: mst_q <= M_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ack_left_q <= 2'h0;
			ack_idx_q <= 2'h0;
			vector_q <= 24'h00_0000;
		end else if (ack_launch) begin
			ack_left_q <= ack_total;
			ack_idx_q <= 2'h0;
			vector_q <= 24'h00_0000;
		end else if (mst_q == M_ACK && seq_done) begin
			vector_q[{ack_idx_q, 3'b000} +: 8] <= seq_rdata;
			ack_left_q <= ack_left_q - 2'h1;
			ack_idx_q <= ack_idx_q + 2'h1;
		end
	end

	vicp_strobe u_strobe (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(seq_start),
		.kind(seq_kind),
		.port_sel(seq_ps),
		.wdata(hwdata[7:0]),
		.d_in(data_in),
		.busy(seq_busy),
		.done_q(seq_done),
		.rdata_q(seq_rdata),
		.cs_n_q(cs_n),
		.wr_n_q(wr_n),
		.rd_n_q(rd_n),
		.ack_n_q(ack_strobe_n),
		.ps_q(port_select_bit),
		.d_out_q(data_out),
		.d_oe_q(data_oe)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [1:0] ack_seen_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_n || ack_launch) ack_seen_q <= 2'h0;
		else if ($fell(ack_strobe_n)) ack_seen_q <= ack_seen_q + 2'h1;
	end

	a_ps_follows_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(cs_n) |-> port_select_bit == dph_addr_q[vicp_pkg::DEV_PS_BIT]) else $error("Port select not from address");
	a_dev_access_stall: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(a_acc && vicp_is_dev(haddr[7:0])) |=> !hreadyout ##[1:40] !cs_n) else $error("Device access did not start");
	a_dev_ready_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(mst_q == M_BUS && seq_done) |=> hreadyout && mst_q == M_IDLE) else $error("Ready not back after device cycle");
	a_ack_without_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ack_strobe_n |-> cs_n && !data_oe) else $error("Acknowledge pulse with select or drive");
	a_ack_pulse_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(mst_q == M_ACK && seq_done && ack_left_q == 2'h1) |-> ack_seen_q == ack_total) else $error("Wrong pulse count");
	a_role_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(buffered_q) |=> !role_select_or_buffer_gate_oe) else $error("Role pin still driven in buffered mode");

	c_dev_write: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(wr_n));
	c_dev_read: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(rd_n));
	c_ack_three: cover property (@(posedge clk_sys) disable iff (!rst_n)
		(mst_q == M_ACK && seq_done && ack_left_q == 2'h1 && ack_total == 2'h3));
	c_auto_ack: cover property (@(posedge clk_sys) disable iff (!rst_n) ack_launch && !ack_go_q);
endmodule : vicp_host

// ---- src/vicp_pkg.sv ----
// Shared constants for the host controller of the vectored interrupt controller pins
// What this block does
// - Host pulls write strobe low under select; device takes bus byte as command
// - Host ties port select bit to address bit 2, its lowest word address line
// - Level mode: a high request line counts, held high until acknowledged
// - CPU issues acknowledge pulses; device puts vector bytes on the bus meanwhile
package vicp_pkg;
	// ----------------------------------------
	// Strobe timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int T_SETUP_NS = 10;
	localparam int T_STROBE_NS = 40;
	localparam int T_HOLD_NS = 10;
	localparam int T_RECOVER_NS = 20;
	localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] STROBE_CYC = 8'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] RECOVER_CYC = 8'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_VECTOR = 8'h08;
	localparam logic [7:0] OFS_LAST_RD = 8'h0C;
	localparam logic [7:0] OFS_DEV_PORT0 = 8'h10;
	localparam logic [7:0] OFS_DEV_PORT1 = 8'h14;
	localparam int DEV_PS_BIT = 2;

	// ----------------------------------------
	// Field layout and reset values
	// ----------------------------------------
	localparam int CTRL_ACK_GO = 0;
	localparam int CTRL_AUTO_ACK = 1;
	localparam int CTRL_BUFFERED = 2;
	localparam int CTRL_MASTER = 3;
	localparam int CTRL_ACK_CNT_LSB = 4;
	localparam logic CTRL_MASTER_RST = 1'b1;
	localparam logic [1:0] CTRL_ACK_CNT_RST = 2'h2;
	localparam int ST_BUSY = 0;
	localparam int ST_INT = 1;
	localparam int ST_GATE = 2;
	localparam int ST_CHAIN_LSB = 8;

	typedef enum logic [1:0] {
		VICP_K_WRITE = 2'b00,
		VICP_K_READ = 2'b01,
		VICP_K_ACK = 2'b10
	} vicp_kind_e;
endpackage : vicp_pkg

// ---- src/vicp_strobe.sv ----
`timescale 1ns/1ps
// Strobe engine that runs one write, read or acknowledge cycle on the device pins
module vicp_strobe (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire vicp_pkg::vicp_kind_e kind,
	input wire logic port_sel,
	input wire logic [7:0] wdata,
	input wire logic [7:0] d_in,
	output logic busy,
	output logic done_q,
	output logic [7:0] rdata_q,
	output logic cs_n_q,
	output logic wr_n_q,
	output logic rd_n_q,
	output logic ack_n_q,
	output logic ps_q,
	output logic [7:0] d_out_q,
	output logic d_oe_q
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SETUP = 3'b001,
		S_STROBE = 3'b010,
		S_HOLD = 3'b011,
		S_RECOVER = 3'b100
	} vicp_seq_e;

	vicp_seq_e st_q;
	vicp_pkg::vicp_kind_e kind_q;
	logic [7:0] cnt_q;
	logic last;

	assign busy = (st_q != S_IDLE);
	assign last = (cnt_q == 8'h00);

	// Phase sequencing and counter
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
			cnt_q <= 8'h00;
			kind_q <= vicp_pkg::VICP_K_WRITE;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				S_IDLE: if (start) begin
					kind_q <= kind;
					cnt_q <= vicp_pkg::SETUP_CYC - 8'h01;
					st_q <= S_SETUP;
				end
				S_SETUP: if (last) begin
					cnt_q <= vicp_pkg::STROBE_CYC - 8'h01;
					st_q <= S_STROBE;
				end else cnt_q <= cnt_q - 8'h01;
				S_STROBE: if (last) begin
					cnt_q <= vicp_pkg::HOLD_CYC - 8'h01;
					st_q <= S_HOLD;
				end else cnt_q <= cnt_q - 8'h01;
				S_HOLD: if (last) begin
					cnt_q <= vicp_pkg::RECOVER_CYC - 8'h01;
					st_q <= S_RECOVER;
				end else cnt_q <= cnt_q - 8'h01;
				S_RECOVER: if (last) begin
					done_q <= 1'b1;
					st_q <= S_IDLE;
				end else cnt_q <= cnt_q - 8'h01;
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// Select and strobe pins
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cs_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			ack_n_q <= 1'b1;
			ps_q <= 1'b0;
		end else begin
			if (st_q == S_IDLE && start) begin
				cs_n_q <= (kind == vicp_pkg::VICP_K_ACK);
				ps_q <= port_sel;
			end else if (st_q == S_HOLD && last) begin
				cs_n_q <= 1'b1;
			end
			if (st_q == S_SETUP && last) begin
				wr_n_q <= (kind_q != vicp_pkg::VICP_K_WRITE);
				rd_n_q <= (kind_q != vicp_pkg::VICP_K_READ);
				ack_n_q <= (kind_q != vicp_pkg::VICP_K_ACK);
			end else if (st_q == S_STROBE && last) begin
				wr_n_q <= 1'b1;
				rd_n_q <= 1'b1;
				ack_n_q <= 1'b1;
			end
		end
	end

	// Data bus drive and capture
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			d_out_q <= 8'h00;
			d_oe_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			if (st_q == S_IDLE && start) begin
				d_out_q <= wdata;
				d_oe_q <= (kind == vicp_pkg::VICP_K_WRITE);
			end else if (st_q == S_HOLD && last) begin
				d_oe_q <= 1'b0;
			end
			if (st_q == S_STROBE && last && kind_q != vicp_pkg::VICP_K_WRITE) begin
				rdata_q <= d_in;
			end
		end
	end

	a_strobe_needs_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!wr_n_q || !rd_n_q) |-> !cs_n_q) else $error("Read or write strobe without select");
	a_write_drives_bus: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!wr_n_q |-> d_oe_q && $stable(d_out_q)) else $error("Write strobe without stable driven data");
	a_read_releases_bus: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!rd_n_q || !ack_n_q) |-> !d_oe_q) else $error("Host drives bus while device answers");
	a_strobe_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(wr_n_q && rd_n_q && ack_n_q) |-> !(wr_n_q && rd_n_q && ack_n_q) [*8] ##1 (wr_n_q && rd_n_q && ack_n_q))
		else $error("Strobe low time wrong");
endmodule : vicp_strobe

// ---- tb/vicp_dev_model.sv ----
`timescale 1ns/1ps
// Behavioural model of the vectored interrupt controller seen from its pins
module vicp_dev_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic ack_strobe_n,
	input wire logic port_select_bit,
	input wire logic [7:0] data_bus,
	output logic [7:0] data_drv,
	output logic data_drv_oe,
	output logic [2:0] chain_out,
	output logic chain_oe,
	input wire logic gate_wire,
	output logic gate_out,
	output logic gate_oe,
	input wire logic [7:0] level_request_lines,
	output logic int_q
);
	// Upper bits of every vector byte, arbitrary
	localparam logic [2:0] VEC_BASE = 3'h6;
	localparam logic [1:0] NPULSE = 2'h2;
	logic [7:0] req_m_q, req_s_q, mask_q, isr_q, last_q, allow, cand;
	logic [2:0] top, lvl_q, lvl_now;
	logic [1:0] idx_q;
	logic wr_prev_q, ack_prev_q, buf_q, master_q, drv_rd, drv_ack;

	// ----------------------------------------
	// Priority resolution
	// ----------------------------------------
	// eight levels, mask, outrank check
	always_comb begin
		allow = 8'hFF;
		for (int i = 7; i >= 0; i--) if (isr_q[i]) allow = 8'((9'h001 << i) - 9'h001);
		cand = req_s_q & ~mask_q & allow;
		top = 3'h0;
		for (int i = 7; i >= 0; i--) if (cand[i]) top = 3'(i);
	end

	// ----------------------------------------
	// Bus drive
	// ----------------------------------------
	// status on read, vector on acknowledge
	always_comb begin
		drv_rd = !cs_n && !rd_n;
		drv_ack = !ack_strobe_n;
		lvl_now = (idx_q == 2'h0 && ack_prev_q) ? top : lvl_q;
		data_drv_oe = drv_rd || drv_ack;
		if (drv_ack) data_drv = {VEC_BASE, idx_q, lvl_now};
		else if (drv_rd) data_drv = port_select_bit ? mask_q : req_s_q;
		else data_drv = ~last_q; // Released bus shows no stale value
	end

	// chain lines and dual pin by role
	assign chain_oe = master_q;
	assign chain_out = lvl_q;
	assign gate_oe = buf_q;
	assign gate_out = buf_q ? data_drv_oe : 1'b0;

	// Bus history for the released value
	always_ff @(posedge clk_sys) begin
		if (!rst_n) last_q <= 8'h00;
		else if (data_drv_oe) last_q <= data_drv;
	end

	always_ff @(posedge clk_sys) begin
		req_m_q <= rst_n ? level_request_lines : 8'h00;
		req_s_q <= rst_n ? req_m_q : 8'h00;
		int_q <= rst_n && (cand != 8'h00);
	end

	always_ff @(posedge clk_sys) begin
		wr_prev_q <= rst_n ? wr_n : 1'b1;
		if (!rst_n) begin
			mask_q <= 8'h00;
			buf_q <= 1'b0;
		end else if (!cs_n && wr_n && !wr_prev_q) begin
			if (port_select_bit) mask_q <= data_bus;
			else buf_q <= data_bus[3];
		end
		if (!rst_n) master_q <= 1'b1;
		else if (!buf_q) master_q <= gate_wire;
	end

	// in-service set on the first acknowledge pulse
	always_ff @(posedge clk_sys) begin
		ack_prev_q <= rst_n ? ack_strobe_n : 1'b1;
		if (!rst_n) begin
			isr_q <= 8'h00;
			idx_q <= 2'h0;
			lvl_q <= 3'h0;
		end else begin
			if (!cs_n && wr_n && !wr_prev_q && !port_select_bit) isr_q <= 8'h00;
			else if (!ack_strobe_n && ack_prev_q && idx_q == 2'h0) begin
				isr_q <= isr_q | (8'h01 << top);
				lvl_q <= top;
			end
			if (ack_strobe_n && !ack_prev_q) idx_q <= (idx_q == NPULSE - 2'h1) ? 2'h0 : idx_q + 2'h1;
		end
	end
endmodule : vicp_dev_model

// ---- tb/vicp_host_tb_top.sv ----
`timescale 1ns/1ps
// Self-checking bench for the host controller against the device model
module vicp_host_tb_top;
	logic clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_v;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, chain_m, chain_w;
	logic [7:0] req = 8'h00, d_host, d_dev, d_w;
	logic hreadyout, hresp, cs_n, wr_n, rd_n, ack_n, ps, d_oe, dev_oe, dev_int;
	logic g_host, g_host_oe, g_dev, g_dev_oe, g_w, c_oe;
	int err_count = 0, checks = 0, cyc = 0;

	always #2.5 clk_sys = ~clk_sys;
	// Wire levels from the host's data and gate enables and the model's chain enable
	assign hready = hreadyout;
	assign d_w = d_oe ? d_host : d_dev;
	assign g_w = g_host_oe ? g_host : g_dev;
	assign chain_w = c_oe ? chain_m : 3'h5; // Another master drives a slave's lines

	vicp_host i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .ack_strobe_n(ack_n),
		.port_select_bit(ps), .data_in(d_w), .data_out(d_host), .data_oe(d_oe), .chain_id_bus(chain_w),
		.role_select_or_buffer_gate_in(g_w), .role_select_or_buffer_gate_out(g_host),
		.role_select_or_buffer_gate_oe(g_host_oe), .int_in(dev_int));
	vicp_dev_model i_dev (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
		.ack_strobe_n(ack_n), .port_select_bit(ps), .data_bus(d_w), .data_drv(d_dev), .data_drv_oe(dev_oe),
		.chain_out(chain_m), .chain_oe(c_oe), .gate_wire(g_w), .gate_out(g_dev), .gate_oe(g_dev_oe),
		.level_request_lines(req), .int_q(dev_int));

	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One single AHB transfer, waiting for the slave at each phase
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd_v = hrdata;
	endtask : xfer

	task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(nm, exp, rd_v);
		chk("hresp_okay", 32'h0, {31'h0, hresp});
	endtask : rd_chk

	// Poll busy clear; wait_int separately watches the interrupt line
	task automatic wait_idle();
		for (int i = 0; i < 100; i++) begin
			xfer(1'b0, 32'h04, 32'h0);
			if (rd_v[0] === 1'b0) break;
		end
		chk("busy_clear", 32'h0, {31'h0, rd_v[0]});
	endtask : wait_idle

	task automatic wait_int(input logic lvl);
		for (int i = 0; i < 50 && dev_int !== lvl; i++) @(posedge clk_sys);
		chk("int_line", {31'h0, lvl}, {31'h0, dev_int});
	endtask : wait_int

	function automatic logic [7:0] vec(input logic [1:0] n, input logic [2:0] l);
		return {3'h6, n, l};
	endfunction : vec

	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	// Both ends driving the data bus at once
	always @(posedge clk_sys) if (d_oe === 1'b1 && dev_oe === 1'b1) begin
		err_count++;
		$display("CHECK FAILED data_bus_contention expected 0 seen 1");
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd_chk("ctrl_reset", 32'h00, 32'h28);
		rd_chk("status_reset", 32'h04, 32'h04);
		xfer(1'b1, 32'h40, 32'hFFFFFFFF);
		xfer(1'b1, 32'h04, 32'hFFFFFFFF);
		rd_chk("unmapped", 32'h40, 32'h0);
		rd_chk("status_ro", 32'h04, 32'h04);
		$display("test reset_and_map done");
		// Port select follows the word address line
		xfer(1'b1, 32'h14, 32'hF0);
		rd_chk("mask_port", 32'h14, 32'hF0);
		rd_chk("last_rd", 32'h0C, 32'hF0);
		req <= 8'h30; // requests on levels 4 and 5, both masked
		rd_chk("pending_port", 32'h10, 32'h30);
		rd_chk("masked_int", 32'h04, 32'h04);
		$display("test device_port done");
		req <= 8'h34;
		wait_int(1'b1);
		rd_chk("status_int", 32'h04, 32'h06);
		xfer(1'b1, 32'h00, 32'h29);
		wait_idle();
		rd_chk("vector_lvl2", 32'h08, {16'h0, vec(2'h1, 3'h2), vec(2'h0, 3'h2)});
		rd_chk("in_service", 32'h04, 32'h204);
		req <= 8'h35;
		wait_int(1'b1);
		rd_chk("outrank_int", 32'h04, 32'h206);
		$display("test ack_master done");
		xfer(1'b1, 32'h10, 32'h08);
		xfer(1'b1, 32'h00, 32'h2D);
		wait_idle();
		rd_chk("vector_lvl0", 32'h08, {16'h0, vec(2'h1, 3'h0), vec(2'h0, 3'h0)});
		rd_chk("buffered_gate", 32'h04, 32'h000);
		$display("test ack_buffered done");
		xfer(1'b1, 32'h10, 32'h00);
		xfer(1'b1, 32'h00, 32'h21);
		wait_idle();
		rd_chk("vector_slave", 32'h08, {16'h0, vec(2'h1, 3'h0), vec(2'h0, 3'h0)});
		rd_chk("slave_chain", 32'h04, 32'h500);
		$display("test ack_slave done");
		// Auto acknowledge, one pulse, launched once the in-service level is cleared
		req <= 8'h08;
		xfer(1'b1, 32'h00, 32'h0A);
		rd_chk("ctrl_auto", 32'h00, 32'h0A);
		xfer(1'b1, 32'h10, 32'h00);
		wait_idle();
		rd_chk("vector_auto", 32'h08, {24'h0, vec(2'h0, 3'h3)});
		rd_chk("auto_chain", 32'h04, 32'h304);
		$display("test ack_auto done");
		end_of_test();
	end
endmodule : vicp_host_tb_top
